/* rtl/ecam_addr_decode.sv */
// Splits a processor address into configuration address fields
`timescale 1ns/1ps
`include "ecam_router_defines.svh"

module ecam_addr_decode
	import ecam_router_pkg::*;
#(
	parameter int          BUS_BITS = 8,
	parameter logic [31:0] BASE     = 32'h4000_0000
)(
	// Address in
	input  wire logic [31:0] addr,
	input  wire logic        ariBus,
	// Fields out
	output ecamFields_t      fields
);

	localparam int TOP = `ECAM_BUS_LSB + BUS_BITS;

	always_comb
	begin
		fields          = '0;
		// One region holds the root port and its whole hierarchy
		fields.inRegion = (addr[31:TOP] == BASE[31:TOP]);
		fields.bus      = 8'(addr[TOP-1:`ECAM_BUS_LSB]);
		fields.dev      = addr[`ECAM_DEV_MSB:`ECAM_DEV_LSB];
		fields.fn       = addr[`ECAM_FN_MSB:`ECAM_FN_LSB];
		fields.extReg   = addr[`ECAM_EXT_MSB:`ECAM_EXT_LSB];
		fields.regNum   = addr[`ECAM_REG_MSB:`ECAM_REG_LSB];
		fields.byteSel  = addr[`ECAM_BYTE_MSB:0];
		if (ariBus)
		begin
			// Device field folds into an 8-bit function number
			fields.dev   = 5'h0_0;
			fields.devFn = addr[`ECAM_DEV_MSB:`ECAM_FN_LSB];
		end
		else
		begin
			fields.devFn = {fields.dev, fields.fn};
		end
	end

endmodule

/* rtl/ecam_root_port_config_router.sv */
// Root port router: configuration decode, local header, downstream routing, memory windows
`timescale 1ns/1ps
`include "ecam_router_defines.svh"

module ecam_root_port_config_router
	import ecam_router_pkg::*;
#(
	parameter int          BUS_BITS  = 8,
	parameter logic [31:0] ECAM_BASE = 32'h4000_0000,
	parameter logic [31:0] ID_VALUE  = 32'h0001_1234 // Arbitrary identity value
)(
	// Clock and reset
	input  wire logic clk,
	input  wire logic nrst,
	// Processor requests
	input  wire logic reqValid,
	output logic      reqReady,
	input  upReq_t    req,
	// Processor responses
	output logic      rspValid,
	output upRsp_t    rsp,
	// Downstream requests
	output logic      dnValid,
	input  wire logic dnReady,
	output dnReq_t    dn,
	// Downstream completions
	input  wire logic cplValid,
	input  dnCpl_t    cpl,
	// Link state
	input  wire logic dlDown,
	input  wire logic secondaryAri,
	// Error report
	output logic      errReport
);

	// ----------------------------------------
	// State and storage
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_ISSUE = 4'b0010,
		ST_WAIT  = 4'b0100,
		ST_RESP  = 4'b1000
	} state_t;

	state_t      state_q,   state_d;
	dnReq_t      dn_q,      dn_d;
	logic [31:0] rspData_q, rspData_d;
	logic        rspUr_q,   rspUr_d;
	logic        err_q,     err_d;
	logic [31:0] cfg_q [`CFG_DWORDS];
	logic [31:0] cfg_d [`CFG_DWORDS];

	ecamFields_t f;
	logic [7:0]  primBus;
	logic [7:0]  secBus;
	logic [7:0]  subBus;
	logic [15:0] ownId;
	logic [3:0]  be;
	logic        beOk;
	logic        inWindow;
	logic        urReport;
	logic        crsVis;
	logic [9:0]  dwIdx;

	// ----------------------------------------
	// Header reset values and write masks
	// ----------------------------------------
	function automatic logic [31:0] cfgReset(input int idx);
		case (5'(idx))
			`CFG_IDX_ID:      cfgReset = ID_VALUE;
			`CFG_IDX_CLASS:   cfgReset = `CFG_RST_CLASS;
			`CFG_IDX_HDR:     cfgReset = `CFG_RST_HDR;
			`CFG_IDX_BUS:     cfgReset = `CFG_RST_BUS;
			`CFG_IDX_MEMWIN:  cfgReset = `CFG_RST_WIN;
			`CFG_IDX_PREFWIN: cfgReset = `CFG_RST_WIN;
			`CFG_IDX_CAPPTR:  cfgReset = `CFG_RST_CAPPTR;
			`CFG_IDX_EXPCAP:  cfgReset = `CFG_RST_EXPCAP;
			`CFG_IDX_ROOTCTL: cfgReset = `CFG_RST_ROOTCTL;
			default:          cfgReset = 32'h0000_0000;
		endcase
	endfunction

	// Read-only bits are zero in the mask
	function automatic logic [31:0] cfgMask(input int idx);
		case (5'(idx))
			`CFG_IDX_CMD:     cfgMask = `CFG_WM_CMD;
			`CFG_IDX_HDR:     cfgMask = `CFG_WM_HDR;
			`CFG_IDX_BUS:     cfgMask = `CFG_WM_BUS;
			`CFG_IDX_MEMWIN:  cfgMask = `CFG_WM_WIN;
			`CFG_IDX_PREFWIN: cfgMask = `CFG_WM_WIN;
			`CFG_IDX_BRCTL:   cfgMask = `CFG_WM_BRCTL;
			`CFG_IDX_DEVCTL:  cfgMask = `CFG_WM_DEVCTL;
			`CFG_IDX_ROOTCTL: cfgMask = `CFG_WM_ROOTCTL;
			default:          cfgMask = 32'h0000_0000;
		endcase
	endfunction

	// Inclusive window check, 1 MB granularity
	function automatic logic inWin(input logic [31:0] a, input logic [31:0] w);
		inWin = (a >= {w[15:4], 20'h0_0000}) && (a <= {w[31:20], 20'hF_FFFF});
	endfunction

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	ecam_addr_decode #(
		.BUS_BITS (BUS_BITS),
		.BASE     (ECAM_BASE)
	) u_decode (
		.addr   (req.addr),
		.ariBus (secondaryAri && (req.addr[`ECAM_BUS_LSB+BUS_BITS-1:`ECAM_BUS_LSB] ==
		         BUS_BITS'(cfg_q[`CFG_IDX_BUS][15:8]))),
		.fields (f)
	);

	assign primBus  = cfg_q[`CFG_IDX_BUS][7:0];
	assign secBus   = cfg_q[`CFG_IDX_BUS][15:8];
	assign subBus   = cfg_q[`CFG_IDX_BUS][23:16];
	assign ownId    = {primBus, 8'h00};
	assign urReport = cfg_q[`CFG_IDX_DEVCTL][`DEVCTL_UR_REPORT];
	assign crsVis   = cfg_q[`CFG_IDX_ROOTCTL][`ROOTCTL_CRS_VIS];
	assign dwIdx    = {f.extReg, f.regNum};
	assign inWindow = inWin(req.addr, cfg_q[`CFG_IDX_MEMWIN]) ||
	                  inWin(req.addr, cfg_q[`CFG_IDX_PREFWIN]);

	// Byte enables from size and offset; unaligned or wide sizes refused in the configuration region, memory window requests go down with these enables unchecked
	always_comb
	begin
		be   = 4'h0;
		beOk = 1'b1;
		case (req.size)
			2'd0: be = 4'b0001 << req.addr[1:0];
			2'd1: be = req.addr[0] ? 4'h0 : (4'b0011 << req.addr[1:0]);
			2'd2: be = (req.addr[1:0] == 2'd0) ? 4'hF : 4'h0;
			default: be = 4'h0;
		endcase
		if (be == 4'h0)
		begin
			beOk = 1'b0;
		end
	end

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		logic [31:0] wm;
		wm        = 32'h0000_0000;
		state_d   = state_q;
		dn_d      = dn_q;
		rspData_d = rspData_q;
		rspUr_d   = 1'b0;
		err_d     = 1'b0;
		cfg_d     = cfg_q;
		reqReady  = (state_q == ST_IDLE);
		case (state_q)
			ST_IDLE:
			begin
				if (reqValid)
				begin
					// Default answer: all ones, silent completion for writes
					rspData_d    = `ALL_ONES;
					state_d      = ST_RESP;
					dn_d         = '0;
					dn_d.write   = req.write;
					dn_d.bus     = f.bus;
					dn_d.devFn   = f.devFn;
					dn_d.regNum  = dwIdx;
					dn_d.addr    = req.addr;
					dn_d.be      = be;
					dn_d.wdata   = req.wdata;
					dn_d.reqId   = ownId;
					if (f.inRegion)
					begin
						if (!beOk)
						begin
							rspData_d = `ALL_ONES;
						end
						else if (f.bus == primBus)
						begin
							if (f.dev == 5'h0_0 && f.fn == 3'h0)
							begin
								// Consumed locally, never sent down
								rspData_d = (dwIdx < 10'(`CFG_DWORDS)) ?
								            cfg_q[dwIdx[4:0]] : 32'h0000_0000;
								if (req.write && dwIdx < 10'(`CFG_DWORDS))
								begin
									wm = cfgMask(int'(dwIdx[4:0])) &
									     {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
									cfg_d[dwIdx[4:0]] = (cfg_q[dwIdx[4:0]] & ~wm) |
									                    (req.wdata & wm);
								end
							end
							else
							begin
								err_d = urReport && !req.write;
							end
						end
						else if (dlDown && (f.bus >= secBus) && (f.bus <= subBus))
						begin
							err_d = urReport && !req.write;
						end
						else if (f.bus == secBus)
						begin
							if (secondaryAri || f.dev == 5'h0_0)
							begin
								dn_d.kind = DN_CFG0;
								state_d   = ST_ISSUE;
							end
							else
							begin
								err_d = urReport && !req.write;
							end
						end
						else if ((f.bus > secBus) && (f.bus <= subBus))
						begin
							dn_d.kind = DN_CFG1;
							state_d   = ST_ISSUE;
						end
					end
					else if (inWindow)
					begin
						dn_d.kind = DN_MEM;
						state_d   = ST_ISSUE;
					end
					else
					begin
						rspUr_d = 1'b1;
						err_d   = urReport;
					end
				end
			end
			ST_ISSUE:
			begin
				if (dnReady)
				begin
					// Posted memory writes finish once taken
					if (dn_q.kind == DN_MEM && dn_q.write)
					begin
						rspData_d = 32'h0000_0000;
						state_d   = ST_RESP;
					end
					else
					begin
						state_d = ST_WAIT;
					end
				end
			end
			ST_WAIT:
			begin
				if (cplValid)
				begin
					state_d   = ST_RESP;
					rspData_d = `ALL_ONES;
					case (cpl.status)
						CPL_OK:
						begin
							rspData_d = cpl.rdata;
						end
						CPL_UR:
						begin
							rspUr_d = (dn_q.kind == DN_MEM);
							err_d   = urReport && !dn_q.write;
						end
						CPL_CRS:
						begin
							// With CRS visibility on, any full read of dword 0 sees the retry pattern; other configuration requests retry, other memory requests get all ones
							if (crsVis && !dn_q.write && dn_q.regNum == 10'h000 &&
							    dn_q.be == 4'hF)
							begin
								rspData_d = `CRS_VISIBLE_DATA;
							end
							else if (dn_q.kind != DN_MEM)
							begin
								state_d = ST_ISSUE;
							end
						end
						default:
						begin
							rspData_d = `ALL_ONES;
						end
					endcase
				end
				else if (dlDown && dn_q.kind != DN_MEM)
				begin
					// Lost completion behind a dropped link
					rspData_d = `ALL_ONES;
					err_d     = urReport && !dn_q.write;
					state_d   = ST_RESP;
				end
			end
			ST_RESP:
			begin
				rspUr_d = rspUr_q;
				state_d = ST_IDLE;
			end
			default:
			begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	// Header resets to a usable bus range so probing works at once
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_q   <= ST_IDLE;
			dn_q      <= '0;
			rspData_q <= 32'h0000_0000;
			rspUr_q   <= 1'b0;
			err_q     <= 1'b0;
			for (int i = 0; i < `CFG_DWORDS; i++)
			begin
				cfg_q[i] <= cfgReset(i);
			end
		end
		else
		begin
			state_q   <= state_d;
			dn_q      <= dn_d;
			rspData_q <= rspData_d;
			rspUr_q   <= rspUr_d;
			err_q     <= err_d;
			cfg_q     <= cfg_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign dnValid   = (state_q == ST_ISSUE);
	assign dn        = dn_q;
	assign rspValid  = (state_q == ST_RESP);
	assign rsp.rdata = rspData_q;
	assign rsp.ur    = rspUr_q;
	assign rsp.cplId = ownId;
	assign errReport = err_q;

endmodule

/* rtl/ecam_router_defines.svh */
// Constants of the configuration router: address fields, register offsets, reset values
`ifndef ECAM_ROUTER_DEFINES_SVH
`define ECAM_ROUTER_DEFINES_SVH

// ----------------------------------------
// Address fields
// ----------------------------------------
`define ECAM_BUS_LSB      20
`define ECAM_DEV_MSB      19
`define ECAM_DEV_LSB      15
`define ECAM_FN_MSB       14
`define ECAM_FN_LSB       12
`define ECAM_EXT_MSB      11
`define ECAM_EXT_LSB      8
`define ECAM_REG_MSB      7
`define ECAM_REG_LSB      2
`define ECAM_BYTE_MSB     1

// ----------------------------------------
// Root port header, dword indices
// ----------------------------------------
`define CFG_IDX_ID        5'd0
`define CFG_IDX_CMD       5'd1
`define CFG_IDX_CLASS     5'd2
`define CFG_IDX_HDR       5'd3
`define CFG_IDX_BUS       5'd6
`define CFG_IDX_MEMWIN    5'd8
`define CFG_IDX_PREFWIN   5'd9
`define CFG_IDX_CAPPTR    5'd13
`define CFG_IDX_BRCTL     5'd15
`define CFG_IDX_EXPCAP    5'd16
`define CFG_IDX_DEVCTL    5'd18
`define CFG_IDX_ROOTCTL   5'd23
`define CFG_DWORDS        24

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define CFG_RST_CLASS     32'h0604_0000
`define CFG_RST_HDR       32'h0001_0000
`define CFG_RST_BUS       32'h00FF_0100
`define CFG_RST_WIN       32'h0000_FFF0
`define CFG_RST_CAPPTR    32'h0000_0040
`define CFG_RST_EXPCAP    32'h0042_0010
`define CFG_RST_ROOTCTL   32'h0001_0000
`define CFG_WM_CMD        32'h0000_0147
`define CFG_WM_HDR        32'h0000_00FF
`define CFG_WM_BUS        32'h00FF_FFFF
`define CFG_WM_WIN        32'hFFF0_FFF0
`define CFG_WM_BRCTL      32'h003F_00FF
`define CFG_WM_DEVCTL     32'h0000_00FF
`define CFG_WM_ROOTCTL    32'h0000_001F

// ----------------------------------------
// Field bits and fixed data
// ----------------------------------------
`define DEVCTL_UR_REPORT  3
`define ROOTCTL_CRS_VIS   4
`define ALL_ONES          32'hFFFF_FFFF
`define CRS_VISIBLE_DATA  32'hFFFF_0001

`endif

/* rtl/ecam_router_pkg.sv */
// Types shared by the configuration router modules
package ecam_router_pkg;

	typedef enum logic [1:0] {
		CPL_OK    = 2'h0,
		CPL_UR    = 2'h1,
		CPL_CRS   = 2'h2,
		CPL_ABORT = 2'h3
	} cplStatus_t;

	typedef enum logic [1:0] {
		DN_CFG0 = 2'h0,
		DN_CFG1 = 2'h1,
		DN_MEM  = 2'h2
	} dnKind_t;

	typedef struct packed {
		logic [31:0] addr;
		logic        write;
		logic [1:0]  size;
		logic [31:0] wdata;
	} upReq_t;

	typedef struct packed {
		logic [31:0] rdata;
		logic        ur;
		logic [15:0] cplId;
	} upRsp_t;

	typedef struct packed {
		dnKind_t     kind;
		logic        write;
		logic [7:0]  bus;
		logic [7:0]  devFn;
		logic [9:0]  regNum;
		logic [31:0] addr;
		logic [3:0]  be;
		logic [31:0] wdata;
		logic [15:0] reqId;
	} dnReq_t;

	typedef struct packed {
		cplStatus_t  status;
		logic [31:0] rdata;
	} dnCpl_t;

	typedef struct packed {
		logic        inRegion;
		logic [7:0]  bus;
		logic [4:0]  dev;
		logic [2:0]  fn;
		logic [7:0]  devFn;
		logic [3:0]  extReg;
		logic [5:0]  regNum;
		logic [1:0]  byteSel;
	} ecamFields_t;

endpackage

/* sim/downstream_model.sv */
// Downstream partner: takes requests, returns completions
`timescale 1ns/1ps

module downstream_model
	import ecam_router_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       nrst,
	// Requests
	input  wire logic       dnValid,
	output logic            dnReady,
	input  dnReq_t          dn,
	// Completions
	output logic            cplValid,
	output dnCpl_t          cpl,
	// Bench control
	input  cplStatus_t      mode,
	input  wire logic [3:0] lat
);
	dnReq_t     lastDn;
	int         takes;
	logic [3:0] cnt;
	logic       owe;
	wire        take = dnValid && dnReady;

	// Slow mode waits lat cycles before ready and before completion
	always @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			dnReady <= 0;
			cplValid <= 0;
			cpl <= '0;
			owe <= 0;
			cnt <= 0;
			takes <= 0;
		end
		else
		begin
			// One assignment per signal and edge
			dnReady  <= !take && cnt == 0 && !owe && dnValid;
			cplValid <= !take && cnt == 0 && owe;
			if (!take && cnt == 0 && owe)
				cpl <= '{mode, 32'h5A5A_5A5A};
			else
				cpl.rdata <= ~cpl.rdata; // Idle data never looks valid
			if (take)
			begin
				lastDn <= dn;
				takes <= takes + 1;
				owe <= !(dn.kind == DN_MEM && dn.write);
				cnt <= lat;
			end
			else if (cnt != 0)
				cnt <= cnt - 1;
			else if (owe)
			begin
				owe <= 0;
				cnt <= lat;
			end
		end
endmodule

/* sim/ecam_root_port_config_router_tb.sv */
// Self-checking bench of the configuration router
`timescale 1ns/1ps

module ecam_root_port_config_router_tb
	import ecam_router_pkg::*;
;
	localparam logic [31:0] ID  = 32'h0002_5A5A; // Arbitrary identity value
	localparam logic [31:0] ONE = 32'hFFFF_FFFF;
	logic        clk = 0;
	logic        nrst = 0;
	logic        reqValid = 0;
	logic        reqReady;
	upReq_t      req = '0;
	logic        rspValid;
	upRsp_t      rsp;
	logic        dnValid;
	logic        dnReady;
	dnReq_t      dn;
	logic        cplValid;
	dnCpl_t      cpl;
	logic        dlDown = 0;
	logic        secondaryAri = 0;
	logic        errReport;
	cplStatus_t  mode = CPL_OK;
	logic [3:0]  lat = 0;
	logic [31:0] r;
	logic        u;
	logic        e;
	int          t0;
	int          failures = 0;
	int          checkCount = 0;

	always #10 clk = ~clk;

	ecam_root_port_config_router #(.ID_VALUE(ID)) dut_u (.clk, .nrst, .reqValid, .reqReady,
		.req, .rspValid, .rsp, .dnValid, .dnReady, .dn, .cplValid, .cpl, .dlDown,
		.secondaryAri, .errReport);
	downstream_model model_u (.clk, .nrst, .dnValid, .dnReady, .dn, .cplValid, .cpl, .mode,
		.lat);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic wrapUp;
		if (failures == 0 && checkCount > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checkCount++;
		if (g !== x)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, x, g);
		end
	endtask

	function automatic logic [31:0] dnv;
		dnv = {model_u.lastDn.kind, model_u.lastDn.bus, model_u.lastDn.devFn,
			model_u.lastDn.regNum, model_u.lastDn.be};
	endfunction

	// One request, held until taken; next one only after the answer cycle
	// Ready and valid are read between edges, never in the edge's own time step
	task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] s,
		input logic [31:0] d);
		int n;
		n = 0;
		req = '{a, w, s, d};
		reqValid = 1;
		while (!reqReady && n < 400)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		@(posedge clk);
		#1;
		reqValid = 0;
		while (!rspValid && n < 400)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n >= 400)
		begin
			failures++;
			wrapUp;
		end
		else
		begin
			r = rsp.rdata;
			u = rsp.ur;
			e = errReport;
			@(posedge clk);
			#1;
		end
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset;
		acc(32'h4000_0000, 0, 2, 0);
		chk("ident", ID, r);
		acc(32'h4000_0018, 0, 2, 0);
		chk("bus numbers", 32'h00FF_0100, r);
		acc(32'h4000_0040, 0, 2, 0);
		chk("express cap", 32'h0042_0010, r);
		chk("local sent", 0, model_u.takes);
		chk("completer id", 32'h0000_0000, rsp.cplId);
		acc(32'h4010_0040, 0, 2, 0);
		chk("type0 request", {DN_CFG0, 8'h01, 8'h00, 10'h010, 4'hF}, dnv());
		chk("type0 data", 32'h5A5A_5A5A, r);
	endtask

	task automatic t_attr;
		acc(32'h4000_0000, 1, 2, ONE);
		acc(32'h4000_0004, 1, 2, ONE);
		acc(32'h4000_0000, 0, 2, 0);
		chk("ident kept", ID, r);
		acc(32'h4000_0004, 0, 2, 0);
		chk("command", 32'h0000_0147, r);
	endtask

	task automatic t_ur(input logic rep);
		mode = CPL_UR;
		acc(32'h4010_0000, 0, 2, 0);
		chk("ur data", ONE, r);
		chk("ur report", rep, e);
		mode = CPL_OK;
	endtask

	task automatic t_bytes;
		acc(32'h4000_001A, 1, 0, 32'h0005_0000);
		acc(32'h4000_0018, 0, 2, 0);
		chk("byte write", 32'h0005_0100, r);
		acc(32'h4000_0048, 1, 1, 32'h0000_FF08);
		acc(32'h4000_0048, 0, 2, 0);
		chk("half write", 32'h0000_0008, r);
		acc(32'h4010_0006, 0, 1, 0);
		chk("half enables", {DN_CFG0, 8'h01, 8'h00, 10'h001, 4'hC}, dnv());
	endtask

	task automatic t_type1;
		lat = 5;
		acc(32'h4051_D108, 0, 2, 0);
		chk("type1 request", {DN_CFG1, 8'h05, 8'h1D, 10'h042, 4'hF}, dnv());
		t0 = model_u.takes;
		acc(32'h4060_0000, 0, 2, 0);
		chk("past subordinate", ONE, r);
		chk("past subordinate sent", t0, model_u.takes);
		lat = 0;
	endtask

	task automatic t_ari;
		t0 = model_u.takes;
		acc(32'h401A_7000, 0, 2, 0);
		chk("plain absent", ONE, r);
		chk("plain sent", t0, model_u.takes);
		secondaryAri = 1;
		acc(32'h401A_7000, 0, 2, 0);
		chk("ari request", {DN_CFG0, 8'h01, 8'hA7, 10'h000, 4'hF}, dnv());
		secondaryAri = 0;
	endtask

	// Unsupported-request reporting is on here, enabled by the half write in t_bytes
	task automatic t_absent;
		t0 = model_u.takes;
		acc(32'h4000_8000, 0, 2, 0);
		chk("absent read", ONE, r);
		chk("absent report", 1, e);
		acc(32'h4000_1004, 1, 2, 0);
		acc(32'h4000_0004, 0, 2, 0);
		chk("command kept", 32'h0000_0147, r);
		chk("absent sent", t0, model_u.takes);
	endtask

	task automatic t_down;
		dlDown = 1;
		t0 = model_u.takes;
		acc(32'h4010_0000, 0, 2, 0);
		chk("down read", ONE, r);
		chk("down report", 1, e);
		acc(32'h4020_0000, 1, 2, ONE);
		chk("down sent", t0, model_u.takes);
		dlDown = 0;
	endtask

	task automatic t_mem;
		acc(32'h5000_0010, 0, 2, 0);
		chk("closed window ur", 1, u);
		acc(32'h4000_0020, 1, 2, 32'h5010_5000);
		acc(32'h5008_0000, 0, 2, 0);
		chk("mem address", 32'h5008_0000, model_u.lastDn.addr);
		chk("mem data", 32'h5A5A_5A5A, r);
		acc(32'h501F_FFFC, 1, 2, ONE);
		chk("limit write", 32'h501F_FFFC, model_u.lastDn.addr);
		acc(32'h5020_0000, 0, 2, 0);
		chk("past limit ur", 1, u);
	endtask

	// A retried request goes down again until the partner stops answering retry
	task automatic t_crs;
		acc(32'h4000_005C, 1, 2, 32'h0000_0010);
		mode = CPL_CRS;
		acc(32'h4010_0000, 0, 2, 0);
		chk("retry visible", 32'hFFFF_0001, r);
		t0 = model_u.takes;
		fork
			acc(32'h4010_0004, 0, 2, 0);
			begin
				repeat (8) @(posedge clk);
				#1;
				mode = CPL_OK;
			end
		join
		chk("retry data", 32'h5A5A_5A5A, r);
		chk("retry reissued", 1, (model_u.takes - t0) > 1);
		mode = CPL_OK;
	endtask

	initial
	begin
		repeat (12) @(posedge clk);
		#1;
		nrst = 1;
		t_reset;
		t_attr;
		t_ur(0);
		t_bytes;
		t_ur(1);
		t_type1;
		t_ari;
		t_absent;
		t_down;
		t_mem;
		t_crs;
		wrapUp;
	end
endmodule

/* sim/ecam_router_assertions.sv */
// Port checker of the configuration router
`timescale 1ns/1ps

module ecam_router_assertions
	import ecam_router_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic nrst,
	// Processor side
	input wire logic reqValid,
	input wire logic reqReady,
	input upReq_t    req,
	input wire logic rspValid,
	input upRsp_t    rsp,
	// Downstream side
	input wire logic dnValid,
	input wire logic dnReady,
	input dnReq_t    dn,
	input wire logic cplValid,
	input dnCpl_t    cpl,
	input wire logic dlDown
);
	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	logic [31:0] addrQ;
	logic        waitQ;
	wire         inCfg = req.addr[31:28] == 4'h4;

	always_ff @(posedge clk or negedge nrst)
		if (!nrst)
		begin
			addrQ <= '0;
			waitQ <= 1'b0;
		end
		else
		begin
			if (reqValid && reqReady)
				addrQ <= req.addr;
			if (dnValid && dnReady && dn.kind != DN_MEM && !dn.write)
				waitQ <= 1'b1;
			else if (rspValid)
				waitQ <= 1'b0;
		end

	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	sequence s_take;
		reqValid && reqReady;
	endsequence

	sequence s_ones;
		rspValid && rsp.rdata == 32'hFFFF_FFFF && !rsp.ur;
	endsequence

	a_local_answer: assert property (s_take ##0 (inCfg && req.addr[27:20] == 8'h00)
		|=> rspValid && !dnValid) else $error("local access late");
	a_absent_ones: assert property (s_take ##0 (inCfg && !req.write
		&& req.addr[27:20] == 8'h00 && req.addr[19:15] != 5'h00) |=> s_ones)
		else $error("absent read wrong");
	a_down_ones: assert property (s_take ##0 (inCfg && dlDown && !req.write
		&& req.addr[27:20] != 8'h00) |=> s_ones) else $error("link down read wrong");
	a_field_route: assert property (dnValid && dn.kind != DN_MEM |-> dn.bus == addrQ[27:20]
		&& dn.devFn == addrQ[19:12] && dn.regNum == addrQ[11:2]) else $error("fields wrong");
	a_type_select: assert property (dnValid && dn.kind != DN_MEM
		|-> (dn.kind == DN_CFG1) == (dn.bus > 8'h01)) else $error("type wrong");
	a_region_split: assert property (dnValid
		|-> (dn.kind == DN_MEM) == (addrQ[31:28] != 4'h4)) else $error("region wrong");
	a_ur_ones: assert property (waitQ && cplValid && cpl.status == CPL_UR |=> s_ones)
		else $error("ur read wrong");
	a_mem_ur: assert property (rspValid && rsp.ur |-> addrQ[31:28] != 4'h4
		&& rsp.rdata == 32'hFFFF_FFFF) else $error("memory ur wrong");
	a_req_id: assert property (dnValid |-> dn.reqId == 16'h0000)
		else $error("requester wrong");
	a_cpl_id: assert property (rspValid |-> rsp.cplId == 16'h0000)
		else $error("completer wrong");
endmodule

bind ecam_root_port_config_router ecam_router_assertions chk_u (.clk, .nrst, .reqValid,
	.reqReady, .req, .rspValid, .rsp, .dnValid, .dnReady, .dn, .cplValid, .cpl, .dlDown);
